// *** rtl/hdc_defs.vh ***
`ifndef HDC_DEFS_VH
`define HDC_DEFS_VH

// Register offsets
`define HDC_OFS_DRIVE_BOOST_CONTROL    8'h1B
`define HDC_OFS_INPUT_LOOP_CONTROL     8'h1C

// Reset values
`define HDC_RST_DRIVE_BOOST_CONTROL    8'h93
`define HDC_RST_INPUT_LOOP_CONTROL     8'hF5

// Field positions, drive_boost_control
`define HDC_BIT_OVERDRIVE_GAIN_BOOST   7
`define HDC_BIT_RESERVED_6             6
`define HDC_BIT_INPUT_COMMON_MODE_BIAS 5
`define HDC_DRIVE_TIME_MSB             4
`define HDC_DRIVE_TIME_LSB             0

// Field positions, input_and_loop_control
`define HDC_BIT_SIGNED_INPUT_SELECT    7
`define HDC_BIT_BRAKE_GAIN_TAPER       6
`define HDC_SAMPLE_TIME_MSB            5
`define HDC_SAMPLE_TIME_LSB            4
`define HDC_BLANKING_TIME_MSB          3
`define HDC_BLANKING_TIME_LSB          2
`define HDC_IDISS_TIME_MSB             1
`define HDC_IDISS_TIME_LSB             0

// Loop gain selection codes
`define HDC_GAIN_NORMAL                2'h0
`define HDC_GAIN_BOOST                 2'h1
`define HDC_GAIN_TAPER                 2'h2

// Timing, in ns, and derived cycle counts at the core clock
`define HDC_CLK_NS                     8
`define HDC_LRA_BASE_NS                500000
`define HDC_LRA_STEP_NS                100000
`define HDC_ERM_BASE_NS                1000000
`define HDC_ERM_STEP_NS                200000
`define HDC_TRIM_NS                    1000
`define HDC_LRA_BASE_CYC               (`HDC_LRA_BASE_NS / `HDC_CLK_NS)
`define HDC_LRA_STEP_CYC               (`HDC_LRA_STEP_NS / `HDC_CLK_NS)
`define HDC_ERM_BASE_CYC               (`HDC_ERM_BASE_NS / `HDC_CLK_NS)
`define HDC_ERM_STEP_CYC               (`HDC_ERM_STEP_NS / `HDC_CLK_NS)
`define HDC_TRIM_CYC                   (`HDC_TRIM_NS / `HDC_CLK_NS)

// Amplitude midpoint (50 %)
`define HDC_MID_LEVEL                  8'h80

`endif

// *** rtl/hdc_drive_timer.v ***
`include "hdc_defs.vh"
`default_nettype none
// Drive-time / sampling-interval timer. In LRA mode the field only seeds an
// estimate that the loop trims; in ERM mode the field is the interval itself.
module hdc_drive_timer #(
  parameter [19:0] LRA_BASE = `HDC_LRA_BASE_CYC,
  parameter [19:0] LRA_STEP = `HDC_LRA_STEP_CYC,
  parameter [19:0] ERM_BASE = `HDC_ERM_BASE_CYC,
  parameter [19:0] ERM_STEP = `HDC_ERM_STEP_CYC,
  parameter [19:0] TRIM     = `HDC_TRIM_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Configuration
  input  wire [4:0]  drive_time,
  input  wire        lra_mode,
  input  wire        run,
  // Real-time trim of the LRA estimate
  input  wire        trim_up,
  input  wire        trim_down,
  // Results
  output reg  [19:0] period,
  output reg         tick
);

  wire [19:0] lra_seed = LRA_BASE + {15'h0, drive_time} * LRA_STEP;
  wire [19:0] erm_int  = ERM_BASE + {15'h0, drive_time} * ERM_STEP;

  reg  [4:0]  last_field;
  reg         last_mode;
  reg  [19:0] count;
  wire        reseed = (drive_time != last_field) || (lra_mode != last_mode);

  always @(posedge core_clk) begin
    if (rst) begin
      last_field <= 5'h13;
      last_mode  <= 1'b0;
      period     <= 20'h0;
      count      <= 20'h0;
      tick       <= 1'b0;
    end else begin
      last_field <= drive_time;
      last_mode  <= lra_mode;
      tick       <= 1'b0;
      if (!lra_mode)
        period <= erm_int;
      else if (reseed || period == 20'h0)
        period <= lra_seed;
      else if (trim_up && !trim_down && period <= 20'hFFFFF - TRIM)
        period <= period + TRIM;
      else if (trim_down && !trim_up && period > TRIM)
        period <= period - TRIM;
      // A period change restarts nothing; the running count is compared with the new value at once
      if (!run) begin
        count <= 20'h0;
      end else if (period != 20'h0 && count >= period - 20'h1) begin
        count <= 20'h0;
        tick  <= 1'b1;
      end else begin
        count <= count + 20'h1;
      end
    end
  end

endmodule // hdc_drive_timer
`default_nettype wire

// *** rtl/hdc_control_regs.v ***
// What this block does
// - Boost bit raises loop gain during overdrive
// - Bias bit drives common-mode onto trigger pin
// - LRA: field seeds drive time, then trimmed
// - ERM: field sets back-EMF sampling interval
// - Select bit picks unsigned or signed input
// - Unsigned: automatic braking, one extra amplitude bit
// - Unsigned: 0/50/100 percent map linearly
// - Signed open-loop: 50 percent zero, brake below
// - Taper bit lowers gain near brake end
`include "hdc_defs.vh"
`default_nettype none
module hdc_control_regs #(
  parameter [19:0] LRA_BASE = `HDC_LRA_BASE_CYC,
  parameter [19:0] LRA_STEP = `HDC_LRA_STEP_CYC,
  parameter [19:0] ERM_BASE = `HDC_ERM_BASE_CYC,
  parameter [19:0] ERM_STEP = `HDC_ERM_STEP_CYC,
  parameter [19:0] TRIM     = `HDC_TRIM_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Register access port, fed by the serial slave
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Actuator and loop state
  input  wire        lra_mode,
  input  wire        closed_loop,
  input  wire        overdrive_phase,
  input  wire        braking,
  input  wire        brake_near_done,
  input  wire        feedback_brake,
  input  wire        drive_run,
  input  wire        trim_up,
  input  wire        trim_down,
  // Playback input sample
  input  wire [7:0]  in_level,
  input  wire        in_valid,
  // Trigger pin common-mode drive
  output wire        input_trigger_pin_bias_en,
  // Loop controls
  output reg  [1:0]  loop_gain_sel,
  output wire [19:0] drive_period,
  output wire        drive_tick,
  output wire [1:0]  sample_time,
  output wire [1:0]  blanking_time,
  output wire [1:0]  idiss_time,
  // Output amplitude
  output reg  [7:0]  out_mag,
  output reg         out_neg,
  output reg         brake_req
);

  reg  [7:0] drive_boost_control;
  reg  [7:0] input_and_loop_control;

  wire       overdrive_gain_boost   = drive_boost_control[`HDC_BIT_OVERDRIVE_GAIN_BOOST];
  wire       input_common_mode_bias = drive_boost_control[`HDC_BIT_INPUT_COMMON_MODE_BIAS];
  wire [4:0] drive_time =
    drive_boost_control[`HDC_DRIVE_TIME_MSB:`HDC_DRIVE_TIME_LSB];
  wire       signed_input_select    = input_and_loop_control[`HDC_BIT_SIGNED_INPUT_SELECT];
  wire       brake_gain_taper       = input_and_loop_control[`HDC_BIT_BRAKE_GAIN_TAPER];

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Writable bits of the first register; the reserved position is left out
  localparam [7:0] BOOST_WR_MASK = ~(8'h01 << `HDC_BIT_RESERVED_6);

  // Value one address reads back; reserved and unmapped bits read zero
  function [7:0] readback;
    input [7:0] addr;
    input [7:0] boost_q;
    input [7:0] loop_q;
    begin
      if (hit(addr, `HDC_OFS_DRIVE_BOOST_CONTROL))
        readback = boost_q & BOOST_WR_MASK;
      else if (hit(addr, `HDC_OFS_INPUT_LOOP_CONTROL))
        readback = loop_q;
      else
        readback = 8'h00;
    end
  endfunction

  // One decode per register, shared by the write path
  wire       boost_wr_en = reg_wr && hit(reg_addr, `HDC_OFS_DRIVE_BOOST_CONTROL);
  wire       loop_wr_en  = reg_wr && hit(reg_addr, `HDC_OFS_INPUT_LOOP_CONTROL);

  // Register writes; reserved bit is never stored
  always @(posedge core_clk) begin
    if (rst) begin
      drive_boost_control    <= `HDC_RST_DRIVE_BOOST_CONTROL;
      input_and_loop_control <= `HDC_RST_INPUT_LOOP_CONTROL;
    end else begin
      if (boost_wr_en)
        drive_boost_control <= reg_wdata & BOOST_WR_MASK;
      if (loop_wr_en)
        input_and_loop_control <= reg_wdata;
    end
  end

  // Read data is registered and holds until the next read
  always @(posedge core_clk) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= readback(reg_addr, drive_boost_control, input_and_loop_control);
  end

  // The host alone decides when bias is proper; the pin simply follows the bit
  assign input_trigger_pin_bias_en = input_common_mode_bias;

  assign sample_time   = input_and_loop_control[`HDC_SAMPLE_TIME_MSB:`HDC_SAMPLE_TIME_LSB];
  assign blanking_time =
    input_and_loop_control[`HDC_BLANKING_TIME_MSB:`HDC_BLANKING_TIME_LSB];
  assign idiss_time    = input_and_loop_control[`HDC_IDISS_TIME_MSB:`HDC_IDISS_TIME_LSB];

  // Loop gain; taper takes priority since overdrive and braking are exclusive
  // in practice and stability near brake end matters more than startup speed
  reg [1:0] next_loop_gain_sel;
  always @* begin
    next_loop_gain_sel = `HDC_GAIN_NORMAL;
    if (braking && brake_near_done && brake_gain_taper)
      next_loop_gain_sel = `HDC_GAIN_TAPER;
    else if (overdrive_phase && overdrive_gain_boost)
      next_loop_gain_sel = `HDC_GAIN_BOOST;
  end

  always @(posedge core_clk) begin
    if (rst)
      loop_gain_sel <= `HDC_GAIN_NORMAL;
    else
      loop_gain_sel <= next_loop_gain_sel;
  end

  // Input interpretation
  wire       above_mid = (in_level >= `HDC_MID_LEVEL);
  wire [7:0] pos_off   = in_level - `HDC_MID_LEVEL;
  wire [7:0] neg_off   = `HDC_MID_LEVEL - in_level;
  // Twice an offset from mid-scale; the vacated low bit copies bit 6 so that
  // the top code still reaches full scale. Signed mode thus loses one bit.
  function [7:0] doubled;
    input [7:0] off;
    begin
      doubled = {off[6:0], off[6]};
    end
  endfunction

  // 0 % lies a full half-range below mid-scale and saturates
  wire [7:0] pos_mag   = doubled(pos_off);
  wire [7:0] neg_mag   = neg_off[7] ? 8'hFF : doubled(neg_off);

  reg [7:0] next_out_mag;
  reg       next_out_neg;
  reg       next_brake_req;
  always @* begin
    next_out_mag   = 8'h00;
    next_out_neg   = 1'b0;
    next_brake_req = 1'b0;
    if (!signed_input_select) begin
      // Unsigned: full eight-bit magnitude, braking left to the loop
      next_out_mag   = in_level;
      next_brake_req = feedback_brake;
    end else if (closed_loop) begin
      // Signed closed-loop: lower half carries no drive
      next_out_mag   = above_mid ? pos_mag : 8'h00;
      next_brake_req = feedback_brake;
    end else if (above_mid) begin
      next_out_mag   = pos_mag;
    end else begin
      next_out_mag   = neg_mag;
      next_out_neg   = 1'b1;
      next_brake_req = 1'b1;
    end
  end

  // Outputs hold between samples so the bridge sees a steady level
  always @(posedge core_clk) begin
    if (rst) begin
      out_mag   <= 8'h00;
      out_neg   <= 1'b0;
      brake_req <= 1'b0;
    end else if (in_valid) begin
      out_mag   <= next_out_mag;
      out_neg   <= next_out_neg;
      brake_req <= next_brake_req;
    end
  end

  // The timer spots field and mode changes itself and reseeds from them
  hdc_drive_timer #(
    .LRA_BASE (LRA_BASE),
    .LRA_STEP (LRA_STEP),
    .ERM_BASE (ERM_BASE),
    .ERM_STEP (ERM_STEP),
    .TRIM     (TRIM)
  ) u_timer (
    .core_clk   (core_clk),
    .rst        (rst),
    .drive_time (drive_time),
    .lra_mode   (lra_mode),
    .run        (drive_run),
    .trim_up    (trim_up),
    .trim_down  (trim_down),
    .period     (drive_period),
    .tick       (drive_tick)
  );

endmodule // hdc_control_regs
`default_nettype wire

// *** test/hdc_control_regs_chk.sv ***
`default_nettype none
module hdc_control_regs_chk #(
  parameter [19:0] LRA_BASE = 20'h0000A,
  parameter [19:0] LRA_STEP = 20'h00002,
  parameter [19:0] ERM_BASE = 20'h00014,
  parameter [19:0] ERM_STEP = 20'h00004
) (
  // Inputs of the block
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic        lra_mode,
  input wire logic        closed_loop,
  input wire logic        overdrive_phase,
  input wire logic        braking,
  input wire logic        brake_near_done,
  input wire logic        feedback_brake,
  input wire logic [7:0]  in_level,
  input wire logic        in_valid,
  // Outputs of the block
  input wire logic [7:0]  reg_rdata,
  input wire logic        input_trigger_pin_bias_en,
  input wire logic [1:0]  loop_gain_sel,
  input wire logic [19:0] drive_period,
  input wire logic [7:0]  out_mag,
  input wire logic        out_neg,
  input wire logic        brake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadows rebuilt from write traffic, so no internal state is peeked at
  logic [7:0] sh_boost;
  logic [7:0] sh_loop;
  logic [1:0] quiet;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always @(posedge core_clk) begin
    if (rst) begin
      sh_boost <= 8'h93;
      sh_loop <= 8'hF5;
    end else if (reg_wr && reg_addr == 8'h1B) begin
      sh_boost <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h1C) begin
      sh_loop <= reg_wdata;
    end
  end
  // Cycles since the period was last reseeded; trims may follow after that
  always @(posedge core_clk) begin
    if (rst || (reg_wr && reg_addr == 8'h1B && reg_wdata[4:0] != sh_boost[4:0])) begin
      quiet <= 2'h0;
    end else if ($changed(lra_mode)) begin
      // A mode change reseeds at this very edge, a field write one edge later
      quiet <= 2'h1;
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end
  a_bias_follows_bit: assert property (input_trigger_pin_bias_en == sh_boost[5])
    else $error("bias enable differs from register");
  a_boost_gain_sel: assert property (!braking |=>
    loop_gain_sel == {1'h0, $past(overdrive_phase && sh_boost[7])})
    else $error("boost gain select wrong");
  a_taper_gain_sel: assert property (braking && brake_near_done && sh_loop[6]
    |=> loop_gain_sel == 2'h2) else $error("taper gain not selected");
  a_reserved_reads_zero: assert property (reg_rd && reg_addr == 8'h1B |=> !reg_rdata[6])
    else $error("reserved bit reads one");
  a_unsigned_pass: assert property (in_valid && !sh_loop[7] |=> out_mag == $past(in_level)
    && !out_neg && brake_req == $past(feedback_brake)) else $error("unsigned mapping wrong");
  a_signed_below_brake: assert property (in_valid && sh_loop[7] && !closed_loop
    && !in_level[7] |=> out_neg && brake_req) else $error("no brake below midpoint");
  a_erm_interval: assert property (quiet == 2'h3 && !lra_mode |->
    drive_period == ERM_BASE + sh_boost[4:0] * ERM_STEP) else $error("sampling interval wrong");
  a_lra_seed_value: assert property (quiet == 2'h1 && lra_mode |->
    drive_period == LRA_BASE + sh_boost[4:0] * LRA_STEP) else $error("drive time seed wrong");
  cover property (in_valid && !sh_loop[7]);
  cover property (loop_gain_sel == 2'h2);
  cover property (quiet == 2'h1 && lra_mode);
endmodule // hdc_control_regs_chk
bind hdc_control_regs hdc_control_regs_chk #(.LRA_BASE(LRA_BASE), .LRA_STEP(LRA_STEP),
  .ERM_BASE(ERM_BASE), .ERM_STEP(ERM_STEP)) hdc_control_regs_chk_inst (.*);
`default_nettype wire

// *** test/hdc_actuator_model.sv ***
`default_nettype none
// Coasting actuator: after drive stops it keeps moving and asks for braking
module hdc_actuator_model (
  // Clock
  input wire logic       core_clk,
  // Drive from the block
  input wire logic [7:0] out_mag,
  // Brake demand seen through back-EMF
  output logic           feedback_brake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] speed = 8'h00;
  always @(posedge core_clk) begin
    speed <= (out_mag != 8'h00) ? out_mag : speed >> 1;
  end
  assign feedback_brake = speed != 8'h00 && out_mag == 8'h00;
endmodule // hdc_actuator_model
`default_nettype wire

// *** test/haptic_drive_control_regs_test.sv ***
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
module haptic_drive_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  int err_total = 0;
  int checks = 0;
  logic core_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, in_valid = 1'h0;
  logic lra_mode = 1'h0, closed_loop = 1'h0, overdrive_phase = 1'h0, trim_up = 1'h0;
  logic braking = 1'h0, brake_near_done = 1'h0;
  logic trim_down = 1'h0, drive_run = 1'h1;
  logic drive_tick;
  logic [1:0] sample_time, blanking_time, idiss_time;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, in_level = 8'h80;
  logic [7:0] reg_rdata, out_mag;
  logic input_trigger_pin_bias_en, out_neg, brake_req, feedback_brake;
  logic [1:0] loop_gain_sel;
  logic [19:0] drive_period;
  hdc_control_regs #(.LRA_BASE(20'h0000A), .LRA_STEP(20'h00002), .ERM_BASE(20'h00014),
    .ERM_STEP(20'h00004), .TRIM(20'h00001)) hdc_control_regs_inst (.*);
  hdc_actuator_model hdc_actuator_model_inst (.core_clk, .out_mag, .feedback_brake);
  initial forever #4 core_clk = ~core_clk;
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    cyc(1);
    reg_wr = 1'h0;
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'h1;
    cyc(1);
    reg_rd = 1'h0;
    `CHK(reg_rdata, e)
    cyc(1);
  endtask
  task automatic inchk(input logic [7:0] l, input logic [9:0] e);
    in_level = l;
    in_valid = 1'h1;
    cyc(1);
    in_valid = 1'h0;
    cyc(1);
    `CHK({out_mag, out_neg, brake_req}, e)
  endtask
  task automatic t_regs;
    rdc(8'h1B, 8'h93);
    rdc(8'h1C, 8'hF5);
    rdc(8'h33, 8'h00);
    wr(8'h1B, 8'hFF); // Analog input with coupling capacitor
    rdc(8'h1B, 8'hBF);
    `CHK(input_trigger_pin_bias_en, 1'h1)
    wr(8'h1B, 8'h13);
    `CHK(input_trigger_pin_bias_en, 1'h0)
    `CHK({sample_time, blanking_time, idiss_time}, 6'h35)
    wr(8'h1C, 8'hE4);
    `CHK({sample_time, blanking_time, idiss_time}, 6'h24)
    rdc(8'h1C, 8'hE4);
    wr(8'h1C, 8'hF5);
  endtask
  task automatic t_gain;
    overdrive_phase = 1'h1;
    cyc(1);
    `CHK(loop_gain_sel, 2'h0)
    wr(8'h1B, 8'h93);
    `CHK(loop_gain_sel, 2'h1)
    braking = 1'h1;
    brake_near_done = 1'h1;
    cyc(1);
    `CHK(loop_gain_sel, 2'h2)
    wr(8'h1C, 8'hB5);
    `CHK(loop_gain_sel, 2'h1)
    {overdrive_phase, braking, brake_near_done} = 3'h0;
  endtask
  task automatic t_timer;
    `CHK(drive_period, 20'h00060)
    wr(8'h1B, 8'h9F); // Longest field, near half the resonant period
    cyc(2);
    `CHK(drive_period, 20'h00090)
    lra_mode = 1'h1;
    cyc(3);
    `CHK(drive_period, 20'h00048)
    trim_up = 1'h1;
    cyc(1);
    trim_up = 1'h0;
    cyc(2);
    `CHK(drive_period, 20'h00049)
    trim_down = 1'h1;
    cyc(1);
    trim_down = 1'h0;
    cyc(1);
    `CHK(drive_period, 20'h00048)
    drive_run = 1'h0;
    cyc(1);
    drive_run = 1'h1;
    cyc(71);
    `CHK(drive_tick, 1'h0)
    cyc(1);
    `CHK(drive_tick, 1'h1)
    cyc(1);
    `CHK(drive_tick, 1'h0)
  endtask
  task automatic t_reset;
    rst = 1'h1;
    cyc(2);
    `CHK(drive_period, 20'h00000)
    `CHK({out_mag, out_neg, brake_req}, 10'h000)
    rst = 1'h0;
    cyc(1);
    `CHK(drive_period, 20'h00030)
    rdc(8'h1B, 8'h93);
    rdc(8'h1C, 8'hF5);
  endtask
  task automatic t_input;
    inchk(8'h80, 10'h000);
    inchk(8'h00, 10'h3FF);
    inchk(8'hC0, 10'h204);
    inchk(8'hFF, 10'h3FC);
    closed_loop = 1'h1;
    inchk(8'h40, 10'h000);
    inchk(8'hC0, 10'h205);
    wr(8'h1C, 8'h35); // Unsigned only with the loop closed
    inchk(8'h00, 10'h000);
    inchk(8'h00, 10'h001);
    inchk(8'h80, 10'h201);
    inchk(8'hFF, 10'h3FC);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    cyc(8);
    rst = 1'h0;
    cyc(4);
    t_regs();
    t_gain();
    t_timer();
    t_input();
    t_reset();
    tally_and_finish();
  end
endmodule // haptic_drive_control_regs_test
`default_nettype wire
